// File: rtl/hfs_syndrome_regs.sv
`timescale 1ns/1ps
module hfs_syndrome_regs
    import hfs_pkg::*;
#(
    parameter int IDX_W = AFS_IDX_W,
    parameter int WAY_W = AFS_WAY_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    // ecc double-bit error report from the cache controllers
    input  wire logic             eccErr,
    input  wire logic             eccL2,
    input  wire logic             eccDataRam,
    input  wire logic [WAY_W-1:0] eccWay,
    input  wire logic [IDX_W-1:0] eccIndex,
    // exception taken to hyp mode
    input  wire logic             excTake,
    input  wire logic [5:0]       excClass,
    input  wire logic             excLen32,
    input  wire logic             excLenValid,
    input  wire logic             excTrapped,
    input  wire logic [24:0]      excIss,
    // coprocessor access port
    input  wire logic             cpValid,
    input  wire logic             cpWrite,
    input  wire logic [4:0]       cpMode,
    input  wire logic             cpNsBit,
    input  wire logic [2:0]       cpOpc1,
    input  wire logic [3:0]       cpCrn,
    input  wire logic [3:0]       cpCrm,
    input  wire logic [2:0]       cpOpc2,
    input  wire logic [31:0]      cpWdata,
    output logic                  cpAck,
    output logic                  cpDenied,
    output logic [31:0]           cpRdata,
    output logic                  asyncValid
);
    hfs_acc_if acc ();
    hfs_acc_e  accKind;

    logic [31:0] asyncSynd_r;
    logic [31:0] asyncSynd_nxt;
    logic [31:0] excSynd_r;
    logic [31:0] excSynd_nxt;
    logic [31:0] rd_nxt;
    logic [24:0] issBuild;
    logic        wrAsync;
    logic        wrSynd;

    assign acc.valid = cpValid;
    assign acc.mode  = cpMode;
    assign acc.nsBit = cpNsBit;
    assign acc.opc1  = cpOpc1;
    assign acc.crn   = cpCrn;
    assign acc.crm   = cpCrm;
    assign acc.opc2  = cpOpc2;

    hfs_access_decode u_dec (
        .acc (acc.dec)
    );

    always_comb begin
        if (!cpValid) begin
            accKind = ACC_NONE;
        // only the read is unknown; a non-secure write is still refused
        end else if (acc.selSynd && acc.unknownRead && !cpWrite) begin
            accKind = ACC_UNKN;
        end else if (!acc.permit) begin
            accKind = ACC_DENIED;
        end else begin
            accKind = ACC_OK;
        end
    end

    assign wrAsync = cpWrite && accKind == ACC_OK && acc.selAsync;
    assign wrSynd  = cpWrite && accKind == ACC_OK && acc.selSynd;

    // asynchronous ecc syndrome; a hardware error wins over a same-cycle
    // software write so that no error is lost
    always_comb begin
        asyncSynd_nxt = asyncSynd_r;
        if (wrAsync) begin
            asyncSynd_nxt = cpWdata;
        end
        if (eccErr) begin
            asyncSynd_nxt = AFS_RESET;
            asyncSynd_nxt[AFS_VALID_BIT] = 1'b1;
            if (eccL2) begin
                asyncSynd_nxt[AFS_L2_BIT] = 1'b1;
            end else begin
                asyncSynd_nxt[AFS_RAM_LSB +: AFS_RAM_W] =
                    eccDataRam ? RAM_ID_DATA : RAM_ID_TAG;
                asyncSynd_nxt[AFS_WAY_LSB +: AFS_WAY_W] =
                    AFS_WAY_W'(eccWay);
                asyncSynd_nxt[AFS_IDX_LSB +: AFS_IDX_W] =
                    AFS_IDX_W'(eccIndex);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            asyncSynd_r <= AFS_RESET;
        end else begin
            asyncSynd_r <= asyncSynd_nxt;
        end
    end

    // instruction-specific syndrome for the taken exception
    always_comb begin
        issBuild = excIss;
        if (excClass != 6'h00 &&
            excClass[5:4] == CLASS_TOP_TRAPPED_PREDICATE_FIELD) begin
            if (excTrapped) begin
                issBuild[ES_CV_BIT] = 1'b1;
                issBuild[ES_TRAPPED_PREDICATE_FIELD_LSB +: ES_TRAPPED_PREDICATE_FIELD_W] = TRAPPED_PREDICATE_FIELD_ALWAYS;
            end else if (!issBuild[ES_CV_BIT]) begin
                issBuild[ES_TRAPPED_PREDICATE_FIELD_LSB +: ES_TRAPPED_PREDICATE_FIELD_W] = '0;
            end
        end
    end

    // exception capture has priority over a software write in one cycle
    always_comb begin
        excSynd_nxt = excSynd_r;
        if (wrSynd) begin
            excSynd_nxt = cpWdata;
        end
        if (excTake) begin
            excSynd_nxt[ES_CLASS_LSB +: ES_CLASS_W] = excClass;
            // zero class: other fields unknown, stored as zero here
            if (excClass == 6'h00) begin
                excSynd_nxt[ES_LEN_BIT] = 1'b0;
                excSynd_nxt[ES_ISS_W-1:0] = '0;
            end else begin
                excSynd_nxt[ES_LEN_BIT] =
                    excLenValid ? excLen32 : 1'b0;
                excSynd_nxt[ES_ISS_W-1:0] = issBuild;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            excSynd_r <= ES_RESET;
        end else begin
            excSynd_r <= excSynd_nxt;
        end
    end

    // read data; unknown values are returned as zero, which is safe
    always_comb begin
        rd_nxt = READ_ZERO;
        if (!cpWrite && accKind == ACC_OK) begin
            if (acc.selAsync) begin
                rd_nxt = asyncSynd_r;
            end else if (acc.selSynd) begin
                rd_nxt = excSynd_r;
            end else if (acc.selIaux) begin
                rd_nxt = READ_ZERO;
            end else if (acc.selPar) begin
                rd_nxt = READ_ZERO;
            end
        end else if (accKind == ACC_UNKN) begin
            rd_nxt = READ_ZERO;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpAck    <= 1'b0;
            cpDenied <= 1'b0;
            cpRdata  <= READ_ZERO;
        end else begin
            cpAck    <= cpValid;
            cpDenied <= (accKind == ACC_DENIED) || acc.unmapped;
            cpRdata  <= rd_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            asyncValid <= 1'b0;
        end else begin
            asyncValid <= asyncSynd_nxt[AFS_VALID_BIT];
        end
    end
endmodule // hfs_syndrome_regs

// File: pkg/hfs_pkg.sv
package hfs_pkg;
    // coprocessor register selectors (opc1, crn, crm, opc2)
    localparam logic [2:0] SEL_OPC1_HYP       = 3'h4;
    localparam logic [3:0] SEL_CRN_FAULT      = 4'h5;
    localparam logic [3:0] SEL_CRN_PAR        = 4'h7;
    localparam logic [3:0] SEL_CRM_AUX        = 4'h1;
    localparam logic [3:0] SEL_CRM_SYND       = 4'h2;
    localparam logic [3:0] SEL_CRM_PAR        = 4'h4;
    localparam logic [2:0] SEL_OPC2_ASYNC     = 3'h0;
    localparam logic [2:0] SEL_OPC2_IAUX      = 3'h1;
    localparam logic [2:0] SEL_OPC2_SYND      = 3'h0;
    localparam logic [2:0] SEL_OPC2_PAR       = 3'h0;

    // asynchronous fault syndrome layout
    localparam int AFS_VALID_BIT  = 31;
    localparam int AFS_RAM_LSB    = 24;
    localparam int AFS_RAM_W      = 7;
    localparam int AFS_L2_BIT     = 23;
    localparam int AFS_WAY_LSB    = 18;
    localparam int AFS_WAY_W      = 5;
    localparam int AFS_IDX_LSB    = 0;
    localparam int AFS_IDX_W      = 18;
    localparam logic [6:0] RAM_ID_TAG  = 7'h08;
    localparam logic [6:0] RAM_ID_DATA = 7'h09;

    // exception syndrome layout
    localparam int ES_CLASS_LSB   = 26;
    localparam int ES_CLASS_W     = 6;
    localparam int ES_LEN_BIT     = 25;
    localparam int ES_ISS_W       = 25;
    localparam int ES_CV_BIT      = 24;
    localparam int ES_TRAPPED_PREDICATE_FIELD_LSB    = 20;
    localparam int ES_TRAPPED_PREDICATE_FIELD_W      = 4;
    localparam logic [3:0] TRAPPED_PREDICATE_FIELD_ALWAYS = 4'he;
    localparam logic [1:0] CLASS_TOP_TRAPPED_PREDICATE_FIELD = 2'h0;

    localparam logic [31:0] AFS_RESET = 32'h0000_0000;
    localparam logic [31:0] ES_RESET  = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // processor modes
    typedef enum logic [4:0] {
        MODE_USR = 5'h10,
        MODE_FIQ = 5'h11,
        MODE_IRQ = 5'h12,
        MODE_SVC = 5'h13,
        MODE_MON = 5'h16,
        MODE_ABT = 5'h17,
        MODE_HYP = 5'h1a,
        MODE_UND = 5'h1b,
        MODE_SYS = 5'h1f
    } hfs_mode_e;

    // access decode outcome
    typedef enum logic [3:0] {
        ACC_NONE   = 4'b0001,
        ACC_OK     = 4'b0010,
        ACC_DENIED = 4'b0100,
        ACC_UNKN   = 4'b1000
    } hfs_acc_e;
endpackage

// File: pkg/hfs_acc_if.sv
`timescale 1ns/1ps
interface hfs_acc_if;
    logic       valid;
    logic [4:0] mode;
    logic       nsBit;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic       selAsync;
    logic       selIaux;
    logic       selSynd;
    logic       selPar;
    logic       permit;
    logic       unknownRead;
    logic       unmapped;
    modport req (output valid, mode, nsBit, opc1, crn, crm, opc2,
                 input selAsync, selIaux, selSynd, selPar, permit,
                 unknownRead, unmapped);
    modport dec (input valid, mode, nsBit, opc1, crn, crm, opc2,
                 output selAsync, selIaux, selSynd, selPar, permit,
                 unknownRead, unmapped);
endinterface

// File: rtl/hfs_access_decode.sv
`timescale 1ns/1ps
module hfs_access_decode
    import hfs_pkg::*;
(
    hfs_acc_if.dec acc
);
    logic hypMode;
    logic monNs;
    logic nsOther;
    logic hypSel;
    assign hypMode = (acc.mode == MODE_HYP);
    assign monNs   = (acc.mode == MODE_MON) && acc.nsBit;
    // in the non-secure world only hyp and monitor mode may reach these registers
    assign nsOther = acc.nsBit && !hypMode && (acc.mode != MODE_MON);
    assign hypSel  = acc.valid && (acc.opc1 == SEL_OPC1_HYP);

    assign acc.selAsync = hypSel && acc.crn == SEL_CRN_FAULT
                        && acc.crm == SEL_CRM_AUX
                        && acc.opc2 == SEL_OPC2_ASYNC;
    assign acc.selIaux  = hypSel && acc.crn == SEL_CRN_FAULT
                        && acc.crm == SEL_CRM_AUX
                        && acc.opc2 == SEL_OPC2_IAUX;
    assign acc.selSynd  = hypSel && acc.crn == SEL_CRN_FAULT
                        && acc.crm == SEL_CRM_SYND
                        && acc.opc2 == SEL_OPC2_SYND;
    assign acc.selPar   = hypSel && acc.crn == SEL_CRN_PAR
                        && acc.crm == SEL_CRM_PAR
                        && acc.opc2 == SEL_OPC2_PAR;
    assign acc.permit   = hypMode || monNs;
    assign acc.unknownRead = nsOther;
    assign acc.unmapped = acc.valid && !(acc.selAsync || acc.selIaux
                        || acc.selSynd || acc.selPar);
endmodule // hfs_access_decode

// File: tb/hfs_chk.sv
`timescale 1ns/1ps
module hfs_chk
    import hfs_pkg::*;
#(
    parameter int IDX_W = AFS_IDX_W,
    parameter int WAY_W = AFS_WAY_W
) (
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic             eccErr,
    input wire logic             eccL2,
    input wire logic             eccDataRam,
    input wire logic [WAY_W-1:0] eccWay,
    input wire logic [IDX_W-1:0] eccIndex,
    input wire logic             excTake,
    input wire logic [5:0]       excClass,
    input wire logic             excLenValid,
    input wire logic             excTrapped,
    input wire logic             cpValid,
    input wire logic             cpWrite,
    input wire logic [4:0]       cpMode,
    input wire logic             cpNsBit,
    input wire logic [2:0]       cpOpc1,
    input wire logic [3:0]       cpCrn,
    input wire logic [3:0]       cpCrm,
    input wire logic [2:0]       cpOpc2,
    input wire logic             cpAck,
    input wire logic             cpDenied,
    input wire logic [31:0]      cpRdata,
    input wire logic             asyncValid
);
    wire [13:0] sel = {cpOpc1, cpCrn, cpCrm, cpOpc2};
    wire        okMode = cpMode == MODE_HYP || (cpMode == MODE_MON && cpNsBit);
    wire        rdHyp = cpValid && !cpWrite && cpMode == MODE_HYP;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence sL1; eccErr && !eccL2; endsequence
    sequence sL2; eccErr && eccL2; endsequence
    sequence sRdA; rdHyp && sel == 14'h2288 && !eccErr; endsequence
    sequence sRdH; rdHyp && sel == 14'h2290 && !excTake; endsequence
    sequence sTrap; excTake && excTrapped && excClass[5:4] == 2'h0
        && excClass != 6'h0; endsequence
    sequence sNoLen; excTake && !excLenValid && excClass != 6'h0;
    endsequence
    AST_VALID: assert property (eccErr |=> asyncValid)
        else $error("valid flag missing after ecc error");
    AST_L2: assert property (
        sL2 ##1 sRdA |=> cpRdata == 32'h8080_0000)
        else $error("level-2 record wrong");
    AST_L1: assert property (sL1 ##1 sRdA |=> cpRdata == {1'b1,
        $past(eccDataRam, 2) ? RAM_ID_DATA : RAM_ID_TAG, 1'b0,
        $past(eccWay, 2), $past(eccIndex, 2)})
        else $error("level-1 record wrong");
    AST_DENY: assert property (
        cpValid && !okMode && sel == 14'h2288 |=> cpDenied && cpRdata == 0)
        else $error("async access not refused");
    AST_GRANT: assert property (
        cpValid && okMode && sel == 14'h2288 |=> !cpDenied)
        else $error("async access refused");
    AST_IAUX: assert property (
        rdHyp && sel == 14'h2289 |=> cpRdata == 0)
        else $error("aux fault register not zero");
    AST_PAR: assert property (
        rdHyp && sel == 14'h23a0 |=> cpRdata == 0)
        else $error("address result not zero");
    AST_CV: assert property (
        sTrap ##1 sRdH |=> cpRdata[24:20] == 5'h1e)
        else $error("condition fields wrong");
    AST_CLASS: assert property (
        excTake ##1 sRdH |=> cpRdata[31:26] == $past(excClass, 2))
        else $error("exception class not recorded");
    AST_LEN: assert property (sNoLen ##1 sRdH |=> !cpRdata[25])
        else $error("length bit set without valid length");
    AST_ACK: assert property (cpValid |=> cpAck)
        else $error("access not acknowledged");
    AST_IDLE: assert property (
        !cpValid |=> !cpAck && !cpDenied && cpRdata == 0)
        else $error("response outside an access");
    AST_UNKWR: assert property (
        cpValid && cpWrite && cpNsBit && cpMode != MODE_HYP
        && cpMode != MODE_MON && sel == 14'h2290 |=> cpDenied)
        else $error("non-secure syndrome write not refused");
    AST_UNK: assert property (
        cpValid && !cpWrite && cpNsBit && cpMode != MODE_HYP
        && cpMode != MODE_MON && sel == 14'h2290 |=> !cpDenied && cpRdata == 0)
        else $error("non-secure syndrome read wrong");
endmodule // hfs_chk

bind hfs_syndrome_regs hfs_chk #(
    .IDX_W (IDX_W),
    .WAY_W (WAY_W)
) u_hfs_chk (
    .clk         (clk),
    .rst_n       (rst_n),
    .eccErr      (eccErr),
    .eccL2       (eccL2),
    .eccDataRam  (eccDataRam),
    .eccWay      (eccWay),
    .eccIndex    (eccIndex),
    .excTake     (excTake),
    .excClass    (excClass),
    .excLenValid (excLenValid),
    .excTrapped  (excTrapped),
    .cpValid     (cpValid),
    .cpWrite     (cpWrite),
    .cpMode      (cpMode),
    .cpNsBit     (cpNsBit),
    .cpOpc1      (cpOpc1),
    .cpCrn       (cpCrn),
    .cpCrm       (cpCrm),
    .cpOpc2      (cpOpc2),
    .cpAck       (cpAck),
    .cpDenied    (cpDenied),
    .cpRdata     (cpRdata),
    .asyncValid  (asyncValid)
);

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import hfs_pkg::*;
;
    localparam logic [13:0] SA = 14'h2288, SI = 14'h2289, SH = 14'h2290;
    localparam logic [13:0] SP = 14'h23a0;
    logic        clk, rst_n, eccErr, eccL2, eccDataRam, excTake, excLen32;
    logic        excLenValid, excTrapped, cpValid, cpWrite, cpNsBit;
    logic        cpAck, cpDenied, asyncValid, ok;
    logic [4:0]  eccWay, cpMode;
    logic [17:0] eccIndex;
    logic [5:0]  excClass;
    logic [5:0]  cls [6] = '{6'h01, 6'h03, 6'h0f, 6'h00, 6'h24, 6'h30};
    logic [24:0] excIss;
    logic [13:0] sel;
    logic [31:0] cpWdata, cpRdata, afs, hyp_exception_syndrome, v;
    logic [33:0] q [$];
    logic [33:0] e;
    hfs_mode_e   m;
    int          err_count = 0, num_checks = 0, seed = 32'h0d4b3439;

    hfs_syndrome_regs u_hfs_syndrome_regs (.clk, .rst_n, .eccErr, .eccL2,
        .eccDataRam, .eccWay, .eccIndex, .excTake, .excClass, .excLen32,
        .excLenValid, .excTrapped, .excIss, .cpValid, .cpWrite, .cpMode,
        .cpNsBit, .cpOpc1(sel[13:11]), .cpCrn(sel[10:7]), .cpCrm(sel[6:3]),
        .cpOpc2(sel[2:0]), .cpWdata, .cpAck, .cpDenied, .cpRdata,
        .asyncValid);

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // each access clears the other strobes so no pulse lasts two edges
    task automatic acc(input logic w, input logic [4:0] md, input logic ns,
                       input logic [13:0] s, input logic [31:0] d, x,
                       input logic den);
        @(posedge clk);
        cpValid <= 1'b1;
        eccErr  <= 1'b0;
        excTake <= 1'b0;
        cpWrite <= w;
        cpMode  <= md;
        cpNsBit <= ns;
        sel     <= s;
        cpWdata <= d;
        q.push_back({w, den, x});
    endtask

    task automatic ecc(input logic l2, dr);
        v = $random(seed);
        @(posedge clk);
        cpValid    <= 1'b0;
        eccErr     <= 1'b1;
        eccL2      <= l2;
        eccDataRam <= dr;
        eccWay     <= v[22:18];
        eccIndex   <= v[17:0];
        afs = l2 ? 32'h8080_0000 : {1'b1, dr ? 7'h09 : 7'h08, 1'b0, v[22:0]};
    endtask

    task automatic exc(input logic [5:0] c, input logic lv, t);
        v = $random(seed);
        @(posedge clk);
        cpValid     <= 1'b0;
        excTake     <= 1'b1;
        excClass    <= c;
        excLen32    <= v[31];
        excLenValid <= lv;
        excTrapped  <= t;
        excIss      <= v[24:0];
        hyp_exception_syndrome = {c, v[31] & lv, v[24:0]};
        if (c[5:4] == 2'h0 && t)
            hyp_exception_syndrome[24:20] = 5'h1e;
        else if (c[5:4] == 2'h0 && !v[24])
            hyp_exception_syndrome[23:20] = 4'h0;
        if (c == 6'h0)
            hyp_exception_syndrome = 32'h0;
    endtask

    // results arrive one cycle after each access, oldest note first
    always @(posedge clk) begin
        if (cpAck === 1'b1) begin
            e = q.pop_front();
            chk("denied", cpDenied, e[32]);
            if (!e[33])
                chk("rdata", cpRdata, e[31:0]);
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {rst_n, eccErr, eccL2, eccDataRam, eccWay, eccIndex, excTake, excClass,
         excLen32, excLenValid, excTrapped, excIss, cpValid, cpWrite, cpMode,
         cpNsBit, sel, cpWdata} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        acc(0, MODE_HYP, 0, SA, 0, 0, 0);
        acc(0, MODE_HYP, 0, SH, 0, 0, 0);
        for (int i = 0; i < 3; i++) begin
            ecc(i[1], i[0]);
            acc(0, MODE_HYP, 0, SA, 0, afs, 0);
        end
        m = m.first();
        do begin
            for (int n = 0; n < 2; n++) begin
                ok = m == MODE_HYP || (m == MODE_MON && n == 1);
                v = $random(seed);
                acc(1, m, n[0], SA, v, 0, !ok);
                if (ok)
                    afs = v;
                acc(0, m, n[0], SA, 0, ok ? afs : 0, !ok);
            end
            m = m.next();
        end while (m != m.first());
        acc(1, MODE_HYP, 0, SA, 0, 0, 0);
        acc(0, MODE_HYP, 0, SA, 0, 0, 0);
        acc(1, MODE_HYP, 0, SI, 32'hffff_ffff, 0, 0);
        acc(0, MODE_HYP, 0, SI, 0, 0, 0);
        acc(0, MODE_HYP, 0, SP, 0, 0, 0);
        acc(0, MODE_HYP, 0, 14'h3fff, 0, 0, 1);
        foreach (cls[k]) begin
            exc(cls[k], k[0], k < 2);
            acc(0, MODE_HYP, 0, SH, 0, hyp_exception_syndrome, 0);
        end
        acc(0, MODE_SVC, 1, SH, 0, 0, 0);
        acc(0, MODE_SVC, 0, SH, 0, 0, 1);
        acc(1, MODE_SVC, 1, SH, 32'hffff_ffff, 0, 1);
        acc(0, MODE_HYP, 0, SH, 0, hyp_exception_syndrome, 0);
        v = {6'h24, 26'h2a5_5a5a};
        acc(1, MODE_HYP, 0, SH, v, 0, 0);
        acc(0, MODE_HYP, 0, SH, 0, v, 0);
        @(posedge clk);
        cpValid <= 1'b0;
        repeat (3) @(posedge clk);
        chk("valid", asyncValid, 0);
        chk("pending", q.size(), 0);
        tally_and_finish();
    end

    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
endmodule // testbench
